// ==== ead_pkg.sv ====
// shared constants, bus carrier and state records for the e1 receive alarm block
// assumes one 10 MHz system clock and an 8-bit register port with one-cycle read data
package ead_pkg;

  // register offsets
  localparam logic [7:0] EAD_OFF_BLOCK_IRQ_ENABLE     = 8'h01;
  localparam logic [7:0] EAD_OFF_ALARM_ERROR_STATUS   = 8'h02;
  localparam logic [7:0] EAD_OFF_ALARM_ERROR_IRQ_EN   = 8'h03;
  localparam logic [7:0] EAD_OFF_IRQ_CONTROL          = 8'h04;
  localparam logic [7:0] EAD_OFF_LINE_STATE           = 8'h05;

  // field positions
  localparam int unsigned EAD_BIT_ALARM_MASTER  = 1;
  localparam int unsigned EAD_BIT_MFRA_CHANGE   = 5;
  localparam int unsigned EAD_BIT_LOS_CHANGE    = 4;
  localparam int unsigned EAD_BIT_BPV           = 3;
  localparam int unsigned EAD_BIT_CLEAR_ON_READ = 0;
  localparam int unsigned EAD_BIT_B8ZS_SELECT   = 1;
  localparam int unsigned EAD_BIT_LIVE_LOS      = 0;
  localparam int unsigned EAD_BIT_LIVE_MFRA     = 1;

  // values after reset
  localparam logic [7:0] EAD_RST_BLOCK_IRQ_ENABLE   = 8'h00;
  localparam logic [7:0] EAD_RST_ALARM_ERROR_STATUS = 8'h00;
  localparam logic [7:0] EAD_RST_ALARM_ERROR_IRQ_EN = 8'h00;
  localparam logic [7:0] EAD_RST_IRQ_CONTROL        = 8'h00;

  // implemented bits of the status register; also masks the enables for the request
  localparam logic [7:0] EAD_SRC_MASK = 8'h38;

  // counts in received bit times
  localparam logic [5:0] EAD_LOS_ZERO_BITS    = 6'h20;
  localparam logic [5:0] EAD_CLEAR_WINDOW     = 6'h20;
  localparam logic [5:0] EAD_CLEAR_ZERO_RUN   = 6'h04;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ead_reg_req_s;

  typedef struct packed {
    logic       seen_pulse;
    logic       last_pos;
    logic [5:0] zero_run;
    logic [5:0] good_bits;
    logic       los;
    logic       bpv;
  } ead_mon_state_s;

  typedef struct packed {
    logic [2:0] sync_clk;
    logic [2:0] sync_pos;
    logic [2:0] sync_neg;
    logic [2:0] sync_ext;
    logic       filt_clk;
    logic       filt_pos;
    logic       filt_neg;
    logic       filt_ext;
    logic       mfra_prev;
    logic       los_prev;
    logic [7:0] block_irq_enable;
    logic [7:0] alarm_error_status;
    logic [7:0] alarm_error_irq_enable;
    logic [7:0] irq_control;
    logic [7:0] rdata;
    logic       irq;
  } ead_top_state_s;

endpackage

// ==== ead_rail_monitor.sv ====
// rail monitor: bipolar violation and rail-based loss of signal per received bit
// assumes bit_stb_in is a one-cycle strobe with rails already synchronised
`timescale 1ns/100ps
module ead_rail_monitor #(
  parameter logic [5:0] LOS_BITS   = ead_pkg::EAD_LOS_ZERO_BITS,
  parameter logic [5:0] CLEAR_BITS = ead_pkg::EAD_CLEAR_WINDOW,
  parameter logic [5:0] ZERO_RUN   = ead_pkg::EAD_CLEAR_ZERO_RUN
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic bit_stb_in,
  input  wire logic pos_in,
  input  wire logic neg_in,
  input  wire logic b8zs_in,
  output logic      bpv_out,
  output logic      los_out
);

  ead_pkg::ead_mon_state_s state_reg;
  ead_pkg::ead_mon_state_s state_next;

  always_comb begin
    logic       pulse;
    logic [5:0] run;
    pulse = pos_in | neg_in;
    run   = 6'h00;
    state_next = state_reg;
    state_next.bpv = 1'b0;
    if (bit_stb_in) begin
      if (pulse) begin
        // both rails high counts as a positive pulse
        state_next.bpv        = state_reg.seen_pulse && (pos_in == state_reg.last_pos);
        state_next.last_pos   = pos_in;
        state_next.seen_pulse = 1'b1;
      end
      if (!pulse && (state_reg.zero_run < LOS_BITS)) begin
        run = state_reg.zero_run + 6'h01;
      end else if (!pulse) begin
        run = state_reg.zero_run;
      end
      state_next.zero_run = run;
    end
    if (!b8zs_in) begin
      // criteria only hold for b8zs coded rails
      state_next.los       = 1'b0;
      state_next.good_bits = 6'h00;
      state_next.zero_run  = 6'h00;
    end else if (bit_stb_in) begin
      if (!state_reg.los) begin
        if (run >= LOS_BITS) begin
          state_next.los       = 1'b1;
          state_next.good_bits = 6'h00;
        end
      end else if (run >= ZERO_RUN) begin
        state_next.good_bits = 6'h00;
      end else if (state_reg.good_bits + 6'h01 >= CLEAR_BITS) begin
        state_next.los       = 1'b0;
        state_next.good_bits = 6'h00;
      end else begin
        state_next.good_bits = state_reg.good_bits + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bpv_out = state_reg.bpv;
  assign los_out = state_reg.los;

endmodule // ead_rail_monitor

// ==== ead_rx_alarm.sv ====
// e1 receive alarm detect: rail sampling, alarm status latching, interrupt request
// assumes rails and line clock arrive from pins; remote alarm level on clk_in
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
module ead_rx_alarm (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire ead_pkg::ead_reg_req_s reg_req_in,
  output logic [7:0]                 reg_rdata_out,
  input  wire logic                  rx_line_clk_in,
  input  wire logic                  rx_positive_rail_in,
  input  wire logic                  rx_negative_rail_in,
  input  wire logic                  ext_signal_loss_in,
  input  wire logic                  multiframe_remote_alarm_in,
  output logic                       los_out,
  output logic                       bpv_out,
  output logic                       irq_out
);

  ead_pkg::ead_top_state_s state_reg;
  ead_pkg::ead_top_state_s state_next;

  logic bit_stb;
  logic mon_bpv;
  logic mon_los;
  logic los_now;
  logic b8zs_sel;

  // rail strobe from the filtered line clock rising edge
  assign bit_stb  = state_next.filt_clk && !state_reg.filt_clk;
  assign b8zs_sel = state_reg.irq_control[ead_pkg::EAD_BIT_B8ZS_SELECT];

  ead_rail_monitor #(
    .LOS_BITS   (ead_pkg::EAD_LOS_ZERO_BITS),
    .CLEAR_BITS (ead_pkg::EAD_CLEAR_WINDOW),
    .ZERO_RUN   (ead_pkg::EAD_CLEAR_ZERO_RUN)
  ) u_rail_monitor (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .bit_stb_in (bit_stb),
    .pos_in     (state_next.filt_pos),
    .neg_in     (state_next.filt_neg),
    .b8zs_in    (b8zs_sel),
    .bpv_out    (mon_bpv),
    .los_out    (mon_los)
  );

  // combined loss: rail criteria or external pin
  assign los_now = mon_los || state_reg.filt_ext;

  always_comb begin
    logic [7:0] events;
    logic [7:0] clr;
    logic [7:0] read_val;
    logic       rd_status;
    logic       wr_status;
    logic       clear_on_read;

    state_next = state_reg;
    events     = 8'h00;
    clr        = 8'h00;
    read_val   = 8'h00;
    rd_status  = 1'b0;
    wr_status  = 1'b0;
    clear_on_read = state_reg.irq_control[ead_pkg::EAD_BIT_CLEAR_ON_READ];

    // three-stage pin synchronisers; stage 0 feeds stage 1 only
    state_next.sync_clk = {state_reg.sync_clk[1:0], rx_line_clk_in};
    state_next.sync_pos = {state_reg.sync_pos[1:0], rx_positive_rail_in};
    state_next.sync_neg = {state_reg.sync_neg[1:0], rx_negative_rail_in};
    state_next.sync_ext = {state_reg.sync_ext[1:0], ext_signal_loss_in};

    // a level counts only once the last two stages agree
    if (state_reg.sync_clk[1] == state_reg.sync_clk[2]) begin
      state_next.filt_clk = state_reg.sync_clk[2];
    end
    if (state_reg.sync_pos[1] == state_reg.sync_pos[2]) begin
      state_next.filt_pos = state_reg.sync_pos[2];
    end
    if (state_reg.sync_neg[1] == state_reg.sync_neg[2]) begin
      state_next.filt_neg = state_reg.sync_neg[2];
    end
    if (state_reg.sync_ext[1] == state_reg.sync_ext[2]) begin
      state_next.filt_ext = state_reg.sync_ext[2];
    end

    // event detection
    state_next.mfra_prev = multiframe_remote_alarm_in;
    if (multiframe_remote_alarm_in != state_reg.mfra_prev) begin
      events[ead_pkg::EAD_BIT_MFRA_CHANGE] = 1'b1;
    end
    state_next.los_prev = los_now;
    if (los_now != state_reg.los_prev) begin
      events[ead_pkg::EAD_BIT_LOS_CHANGE] = 1'b1;
    end
    if (mon_bpv) begin
      events[ead_pkg::EAD_BIT_BPV] = 1'b1;
    end

    // register reads
    case (reg_req_in.addr)
      ead_pkg::EAD_OFF_BLOCK_IRQ_ENABLE: begin
        read_val = state_reg.block_irq_enable;
      end
      ead_pkg::EAD_OFF_ALARM_ERROR_STATUS: begin
        read_val  = state_reg.alarm_error_status;
        rd_status = reg_req_in.rd;
      end
      ead_pkg::EAD_OFF_ALARM_ERROR_IRQ_EN: begin
        read_val = state_reg.alarm_error_irq_enable;
      end
      ead_pkg::EAD_OFF_IRQ_CONTROL: begin
        read_val = state_reg.irq_control;
      end
      ead_pkg::EAD_OFF_LINE_STATE: begin
        read_val[ead_pkg::EAD_BIT_LIVE_LOS]  = state_reg.los_prev;
        read_val[ead_pkg::EAD_BIT_LIVE_MFRA] = state_reg.mfra_prev;
      end
      default: begin
        // unmapped addresses read as zero
        read_val = 8'h00;
      end
    endcase

    // read data stands in the cycle after the strobe only
    state_next.rdata = reg_req_in.rd ? read_val : 8'h00;

    // register writes
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        ead_pkg::EAD_OFF_BLOCK_IRQ_ENABLE: begin
          state_next.block_irq_enable = reg_req_in.wdata;
        end
        ead_pkg::EAD_OFF_ALARM_ERROR_STATUS: begin
          wr_status = 1'b1;
        end
        ead_pkg::EAD_OFF_ALARM_ERROR_IRQ_EN: begin
          state_next.alarm_error_irq_enable = reg_req_in.wdata;
        end
        ead_pkg::EAD_OFF_IRQ_CONTROL: begin
          state_next.irq_control = reg_req_in.wdata;
        end
        default: begin
          // writes elsewhere are ignored
          state_next.irq_control = state_reg.irq_control;
        end
      endcase
    end

    // clearing: a read in clear-on-read mode, else write ones to clear
    if (clear_on_read && rd_status) begin
      clr = ead_pkg::EAD_SRC_MASK;
    end else if (!clear_on_read && wr_status) begin
      clr = reg_req_in.wdata & ead_pkg::EAD_SRC_MASK;
    end

    // bits hold until cleared; a new event beats a clear in the same cycle
    state_next.alarm_error_status =
      ((state_reg.alarm_error_status & ~clr) | events) & ead_pkg::EAD_SRC_MASK;

    // per-source gating, then the block master enable
    state_next.irq =
      (|(state_next.alarm_error_status & state_next.alarm_error_irq_enable
         & ead_pkg::EAD_SRC_MASK))
      && state_next.block_irq_enable[ead_pkg::EAD_BIT_ALARM_MASTER];
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg                        <= '0;
      state_reg.block_irq_enable       <= ead_pkg::EAD_RST_BLOCK_IRQ_ENABLE;
      state_reg.alarm_error_status     <= ead_pkg::EAD_RST_ALARM_ERROR_STATUS;
      state_reg.alarm_error_irq_enable <= ead_pkg::EAD_RST_ALARM_ERROR_IRQ_EN;
      state_reg.irq_control            <= ead_pkg::EAD_RST_IRQ_CONTROL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_out = state_reg.rdata;
  assign los_out       = state_reg.los_prev;
  assign bpv_out       = mon_bpv;
  assign irq_out       = state_reg.irq;

endmodule // ead_rx_alarm

// ==== ead_properties.sv ====
// checker for the e1 receive alarm block: gating, holding and clearing of the request
// assumes it is bound to ead_rx_alarm and sees only that module's ports
`timescale 1ns/100ps
module ead_properties (
  input wire logic                  clk_in,
  input wire logic                  rst_n_in,
  input wire ead_pkg::ead_reg_req_s reg_req_in,
  input wire logic                  ext_signal_loss_in,
  input wire logic                  multiframe_remote_alarm_in,
  input wire logic                  los_out,
  input wire logic                  bpv_out,
  input wire logic                  irq_out
);
  logic [7:0] ae;
  logic [7:0] blk;
  logic       cor;
  logic       rd_st;
  assign rd_st = reg_req_in.rd && reg_req_in.addr == 8'h02;
  // shadow of the enables and the clear-on-read bit, updated on the same edge as the design's registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ae  <= 8'h00;
      blk <= 8'h00;
      cor <= 1'b0;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == 8'h03) ae <= reg_req_in.wdata;
      if (reg_req_in.addr == 8'h01) blk <= reg_req_in.wdata;
      if (reg_req_in.addr == 8'h04) cor <= reg_req_in.wdata[0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_bpv_single: assert property (bpv_out |=> !bpv_out)
    else $error("violation pulse too long");
  a_bpv_irq: assert property (bpv_out && ae[3] && blk[1] |-> ##[1:2] irq_out)
    else $error("violation gave no request");
  a_master_off: assert property (!blk[1] && !$past(blk[1]) |-> !irq_out)
    else $error("request without master enable");
  a_mfra_irq: assert property ($changed(multiframe_remote_alarm_in) && ae[5] && blk[1]
    |-> ##[1:2] irq_out)
    else $error("remote alarm change gave no request");
  a_ext_los: assert property ($rose(ext_signal_loss_in) |-> ##[2:8] los_out)
    else $error("pin loss not declared");
  a_los_irq: assert property ($changed(los_out) && ae[4] && blk[1] |-> ##[0:2] irq_out)
    else $error("loss change gave no request");
  a_irq_hold: assert property (irq_out && !reg_req_in.rd && !reg_req_in.wr
    && !$past(reg_req_in.rd) && !$past(reg_req_in.wr) |=> irq_out)
    else $error("request dropped without access");
  // an event in the read cycle re-sets a bit; a loss event shows as a los_out change one later
  a_read_clear: assert property ((rd_st && cor && !bpv_out && $stable(multiframe_remote_alarm_in))
    ##1 $stable(los_out) |-> !irq_out)
    else $error("read did not clear request");
endmodule // ead_properties
bind ead_rx_alarm ead_properties ead_properties_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .reg_req_in(reg_req_in), .ext_signal_loss_in(ext_signal_loss_in), .los_out(los_out),
  .multiframe_remote_alarm_in(multiframe_remote_alarm_in), .bpv_out(bpv_out), .irq_out(irq_out));

// ==== ead_liu_model.sv ====
// line interface model: one received symbol per call of send, rails then line clock
// assumes clk_in is the system clock; line clock stands low between symbols
`timescale 1ns/100ps
module ead_liu_model (
  input  wire logic clk_in,
  input  wire logic slow_in,
  output logic      line_clk_out,
  output logic      pos_out,
  output logic      neg_out
);
  initial begin
    line_clk_out = 1'b0;
    pos_out = 1'b0;
    neg_out = 1'b0;
  end
  // sym bit0 positive rail, bit1 negative rail
  task automatic send(input logic [1:0] sym);
    int h;
    h = slow_in ? 6 : 3;
    @(posedge clk_in);
    pos_out <= sym[0];
    neg_out <= sym[1];
    repeat (h) @(posedge clk_in);
    line_clk_out <= 1'b1;
    repeat (h) @(posedge clk_in);
    line_clk_out <= 1'b0;
    // rails turn over after the bit so no stale level looks valid
    pos_out <= ~sym[0];
    neg_out <= ~sym[1];
  endtask
endmodule // ead_liu_model

// ==== ead_rx_alarm_test.sv ====
// self-checking bench for the e1 receive alarm block
// assumes ead_liu_model feeds the rails; read data compared from a queue of notes
`timescale 1ns/100ps
module ead_rx_alarm_test;
  logic clk_in, rst_n_in, lclk, pos, neg, ext, mfra, slow, los, bpv, irq;
  logic                  rd_seen = 1'b0;
  int                    bpv_n = 0;
  logic [7:0]            rdata, r;
  logic [1:0]            last;
  ead_pkg::ead_reg_req_s req;
  int                    err_count, num_checks;
  logic [7:0]            exp_q[$];
  ead_rx_alarm ead_rx_alarm_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .rx_line_clk_in(lclk), .rx_positive_rail_in(pos),
    .rx_negative_rail_in(neg), .ext_signal_loss_in(ext), .multiframe_remote_alarm_in(mfra),
    .los_out(los), .bpv_out(bpv), .irq_out(irq));
  ead_liu_model ead_liu_model_i (.clk_in(clk_in), .slow_in(slow), .line_clk_out(lclk),
    .pos_out(pos), .neg_out(neg));
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // wait n edges, then look at irq (l=0) or los (l=1)
  task automatic see(input int n, input bit l, input logic e);
    repeat (n) @(posedge clk_in);
    chk({7'h00, l ? los : irq}, {7'h00, e});
  endtask
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req <= {rd, ~rd, a, d};
    @(posedge clk_in);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 8'h00);
  endtask
  task automatic send(input logic [1:0] sym, input int n);
    repeat (n) begin
      slow <= 1'($urandom % 2);
      ead_liu_model_i.send(sym);
    end
  endtask
  // alternating pulses, each followed by a run of zeros
  task automatic pulses(input int n, input int zeros);
    repeat (n) begin
      last = ~last;
      send(last, 1);
      send(2'b00, zeros);
    end
  endtask
  always @(posedge clk_in) begin
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen <= req.rd;
    // count violation pulses so bpv_out itself is compared
    if (bpv === 1'b1) bpv_n <= bpv_n + 1;
  end
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    end_sim();
  end
  initial begin
    {rst_n_in, ext, mfra, slow} = 4'h0;
    req = '0;
    last = 2'b10;
    r = 8'($urandom(32'h4f3e5d0a));
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h07, 8'h00);
    r = 8'($urandom);
    bus(1'b0, 8'h03, r);
    rd(8'h03, r);
    bus(1'b0, 8'h03, 8'h38);
    bus(1'b0, 8'h01, 8'h02);
    send(2'b01, 2);
    last = 2'b01;
    see(6, 0, 1'b1);
    rd(8'h02, 8'h08);
    rd(8'h02, 8'h08);
    bus(1'b0, 8'h02, 8'h08);
    rd(8'h02, 8'h00);
    see(2, 0, 1'b0);
    pulses(1, 2);
    pulses(2, 0);
    // let a late violation of the last bit reach status before reading it
    see(6, 0, 1'b0);
    rd(8'h02, 8'h00);
    bus(1'b0, 8'h01, 8'h00);
    send(last, 1);
    see(6, 0, 1'b0);
    chk(8'(bpv_n), 8'h02);
    bus(1'b0, 8'h03, 8'h30);
    bus(1'b0, 8'h01, 8'h02);
    see(2, 0, 1'b0);
    bus(1'b0, 8'h03, 8'h38);
    see(3, 0, 1'b1);
    bus(1'b0, 8'h04, 8'h01);
    rd(8'h02, 8'h08);
    rd(8'h02, 8'h00);
    see(2, 0, 1'b0);
    mfra <= 1'b1;
    see(3, 0, 1'b1);
    rd(8'h02, 8'h20);
    rd(8'h05, 8'h02);
    mfra <= 1'b0;
    see(3, 0, 1'b1);
    rd(8'h02, 8'h20);
    bus(1'b0, 8'h04, 8'h03);
    send(2'b00, 31);
    see(6, 1, 1'b0);
    send(2'b00, 1);
    see(6, 1, 1'b1);
    rd(8'h02, 8'h10);
    rd(8'h05, 8'h01);
    pulses(7, 3);
    pulses(1, 2);
    see(6, 1, 1'b1);
    send(2'b00, 1);
    see(6, 1, 1'b0);
    rd(8'h02, 8'h10);
    bus(1'b0, 8'h04, 8'h01);
    send(2'b00, 40);
    see(6, 1, 1'b0);
    ext <= 1'b1;
    see(10, 1, 1'b1);
    rd(8'h02, 8'h10);
    ext <= 1'b0;
    see(10, 1, 1'b0);
    rd(8'h02, 8'h10);
    see(4, 0, 1'b0);
    chk(8'(bpv_n), 8'h02);
    end_sim();
  end
endmodule // ead_rx_alarm_test
